/* File: rtl/sfs_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none
module sfs_supervisor
    import sfs_pkg::*;
#(
    parameter int unsigned DW = 16,
    parameter int unsigned WDG_OPEN = WDG_OPEN_CYC,
    parameter int unsigned WDG_CLOSE = WDG_CLOSE_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic analog_supply_power_reset,
    input wire logic digital_supply_brownout,
    input wire logic osc_tick,
    input wire logic sample_valid,
    input wire logic sample_is_temp,
    input wire logic [DW-1:0] sample_data,
    input wire logic [DW-1:0] calc_result,
    input wire logic calc_saturated,
    input wire logic alive_service,
    input wire logic nonvolatile_checksum_err,
    input wire logic rom_checksum_err,
    input wire logic cycle_checksum_err,
    input wire logic ram_parity_err,
    input wire logic output_decoder_err,
    input wire logic fault_band_strap_pin,
    input wire logic [3:0] link_addr,
    input wire logic [DW-1:0] link_wdata,
    input wire logic link_wr,
    input wire logic link_rd,
    output logic [DW-1:0] link_rdata,
    output logic [11:0] dac_code,
    output logic analog_result_oe,
    output logic conditioning_run,
    output logic [1:0] fault_report_mode,
    output logic self_reset_req
);
    logic strap_s1_r, strap_s2_r, strap_s3_r, high_band_r;
    logic strap_s1_nxt, strap_s2_nxt, strap_s3_nxt, high_band_nxt;
    logic tick_s1_r, tick_s2_r, tick_s3_r;
    logic lock_r, hiz_r, self_rst_en_r;
    logic lock_nxt, hiz_nxt, self_rst_en_nxt;
    logic [NUM_CHECKS-1:0] static_mask_r, static_mask_nxt;
    logic [DW-1:0] br_min_r, br_max_r, t_min_r, t_max_r, step_max_r;
    logic [DW-1:0] br_min_nxt, br_max_nxt, t_min_nxt, t_max_nxt, step_max_nxt;
    logic [DW-1:0] result_r, result_nxt, last_br_r, last_br_nxt, last_t_r, last_t_nxt;
    logic br_seen_r, br_seen_nxt, t_seen_r, t_seen_nxt;
    logic [DW-1:0] rdata_r, rdata_nxt;
    logic [11:0] dac_r, dac_nxt;
    logic [NUM_CHECKS-1:0] status_r, status_nxt, fault_now;
    sfs_mode_t mode_r, mode_nxt;
    logic [$clog2(WDG_CLOSE+1)-1:0] wdg_cnt_r, wdg_cnt_nxt;
    logic wdg_fault_r, wdg_fault_nxt;
    logic [6:0] osc_cnt_r, osc_cnt_nxt;
    logic osc_lost_r, osc_lost_nxt, osc_restart_r, osc_restart_nxt;
    logic cfg_wr, run;
    logic range_br, range_t, plaus_br, plaus_t;

    function automatic logic out_of_range(input logic [DW-1:0] v, input logic [DW-1:0] lo,
                                          input logic [DW-1:0] hi);
        out_of_range = ($signed(v) < $signed(lo)) || ($signed(v) > $signed(hi));
    endfunction : out_of_range

    function automatic logic too_far(input logic [DW-1:0] a, input logic [DW-1:0] b,
                                     input logic [DW-1:0] lim);
        logic [DW:0] d;
        d = {a[DW-1], a} - {b[DW-1], b};
        if (d[DW]) begin
            d = -d;
        end
        too_far = d > {1'b0, lim};
    endfunction : too_far

    // Pin and oscillator inputs come from outside this clock and pass three stages.
    always_comb begin
        strap_s1_nxt = fault_band_strap_pin;
        strap_s2_nxt = strap_s1_r;
        strap_s3_nxt = strap_s2_r;
        high_band_nxt = high_band_r;
        if (strap_s2_r == strap_s3_r) begin
            high_band_nxt = ~strap_s3_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            strap_s1_r <= 1'b1;
            strap_s2_r <= 1'b1;
            strap_s3_r <= 1'b1;
            high_band_r <= 1'b0;
            tick_s1_r <= 1'b0;
            tick_s2_r <= 1'b0;
            tick_s3_r <= 1'b0;
        end else begin
            strap_s1_r <= strap_s1_nxt;
            strap_s2_r <= strap_s2_nxt;
            strap_s3_r <= strap_s3_nxt;
            high_band_r <= high_band_nxt;
            tick_s1_r <= osc_tick;
            tick_s2_r <= tick_s1_r;
            tick_s3_r <= tick_s2_r;
        end
    end

    assign cfg_wr = link_wr && !lock_r;
    assign run = (mode_r != SFS_STATIC_FAULT);

    always_comb begin
        lock_nxt = lock_r;
        hiz_nxt = hiz_r;
        self_rst_en_nxt = self_rst_en_r;
        static_mask_nxt = static_mask_r;
        br_min_nxt = br_min_r;
        br_max_nxt = br_max_r;
        t_min_nxt = t_min_r;
        t_max_nxt = t_max_r;
        step_max_nxt = step_max_r;
        if (cfg_wr) begin
            case (link_addr)
                ADDR_CTRL: begin
                    lock_nxt = lock_r | link_wdata[CTRL_LOCK_BIT];
                    hiz_nxt = link_wdata[CTRL_HIZ_BIT];
                    self_rst_en_nxt = link_wdata[CTRL_SELF_RST_BIT];
                end
                ADDR_STATIC_MASK: static_mask_nxt = link_wdata[NUM_CHECKS-1:0];
                ADDR_BRIDGE_MIN: br_min_nxt = link_wdata;
                ADDR_BRIDGE_MAX: br_max_nxt = link_wdata;
                ADDR_TEMP_MIN: t_min_nxt = link_wdata;
                ADDR_TEMP_MAX: t_max_nxt = link_wdata;
                ADDR_STEP_MAX: step_max_nxt = link_wdata;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lock_r <= 1'b0;
            hiz_r <= 1'b0;
            self_rst_en_r <= 1'b0;
            static_mask_r <= STATIC_MASK_RST;
            br_min_r <= BRIDGE_MIN_RST;
            br_max_r <= BRIDGE_MAX_RST;
            t_min_r <= TEMP_MIN_RST;
            t_max_r <= TEMP_MAX_RST;
            step_max_r <= STEP_MAX_RST;
        end else begin
            lock_r <= lock_nxt;
            hiz_r <= hiz_nxt;
            self_rst_en_r <= self_rst_en_nxt;
            static_mask_r <= static_mask_nxt;
            br_min_r <= br_min_nxt;
            br_max_r <= br_max_nxt;
            t_min_r <= t_min_nxt;
            t_max_r <= t_max_nxt;
            step_max_r <= step_max_nxt;
        end
    end

    // Sample path and range checks.
    always_comb begin
        result_nxt = result_r;
        last_br_nxt = last_br_r;
        last_t_nxt = last_t_r;
        br_seen_nxt = br_seen_r;
        t_seen_nxt = t_seen_r;
        range_br = 1'b0;
        range_t = 1'b0;
        plaus_br = 1'b0;
        plaus_t = 1'b0;
        if (sample_valid && run) begin
            if (sample_is_temp) begin
                range_t = out_of_range(sample_data, t_min_r, t_max_r);
                plaus_t = t_seen_r && too_far(sample_data, last_t_r, step_max_r);
                last_t_nxt = sample_data;
                t_seen_nxt = 1'b1;
            end else begin
                range_br = out_of_range(sample_data, br_min_r, br_max_r);
                plaus_br = br_seen_r && too_far(sample_data, last_br_r, step_max_r);
                last_br_nxt = sample_data;
                br_seen_nxt = 1'b1;
                result_nxt = calc_result;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            result_r <= '0;
            last_br_r <= '0;
            last_t_r <= '0;
            br_seen_r <= 1'b0;
            t_seen_r <= 1'b0;
        end else begin
            result_r <= result_nxt;
            last_br_r <= last_br_nxt;
            last_t_r <= last_t_nxt;
            br_seen_r <= br_seen_nxt;
            t_seen_r <= t_seen_nxt;
        end
    end

    always_comb begin
        wdg_cnt_nxt = wdg_cnt_r;
        wdg_fault_nxt = 1'b0;
        if (run) begin
            if (alive_service) begin
                wdg_fault_nxt = (wdg_cnt_r < WDG_OPEN[$bits(wdg_cnt_r)-1:0]);
                wdg_cnt_nxt = '0;
            end else if (wdg_cnt_r >= WDG_CLOSE[$bits(wdg_cnt_r)-1:0]) begin
                wdg_fault_nxt = 1'b1;
                wdg_cnt_nxt = '0;
            end else begin
                wdg_cnt_nxt = wdg_cnt_r + 1'b1;
            end
        end
    end

    always_comb begin
        osc_cnt_nxt = osc_cnt_r;
        osc_lost_nxt = osc_lost_r;
        osc_restart_nxt = 1'b0;
        if (tick_s2_r != tick_s3_r) begin
            osc_cnt_nxt = '0;
            osc_restart_nxt = osc_lost_r;
            osc_lost_nxt = 1'b0;
        end else if (osc_cnt_r >= OSC_TIMEOUT_CYC[6:0]) begin
            osc_lost_nxt = 1'b1;
        end else begin
            osc_cnt_nxt = osc_cnt_r + 1'b1;
        end
    end

    always_comb begin
        fault_now = '0;
        fault_now[CHK_ANALOG_POR] = analog_supply_power_reset;
        fault_now[CHK_DIGITAL_BOD] = digital_supply_brownout;
        fault_now[CHK_OSC_LOSS] = osc_lost_r;
        fault_now[CHK_NVM_SUM] = nonvolatile_checksum_err;
        fault_now[CHK_ROM_SUM] = rom_checksum_err;
        fault_now[CHK_CYCLE_SUM] = cycle_checksum_err;
        fault_now[CHK_RAM_PARITY] = ram_parity_err;
        fault_now[CHK_ALIVE] = wdg_fault_r;
        fault_now[CHK_CALC_SAT] = calc_saturated && sample_valid && run;
        fault_now[CHK_DEC] = output_decoder_err;
        fault_now[CHK_BRIDGE_RANGE] = range_br;
        fault_now[CHK_BRIDGE_PLAUS] = plaus_br;
        fault_now[CHK_TEMP_RANGE] = range_t;
        fault_now[CHK_TEMP_PLAUS] = plaus_t;
    end

    // Mode control and status.
    always_comb begin
        status_nxt = status_r;
        mode_nxt = mode_r;
        case (mode_r)
            SFS_NORMAL: begin
                status_nxt = status_r | fault_now;
                if (|(fault_now & static_mask_r)) begin
                    mode_nxt = SFS_STATIC_FAULT;
                end else if (|fault_now) begin
                    mode_nxt = SFS_TEMP_FAULT;
                end
            end
            SFS_TEMP_FAULT: begin
                status_nxt = fault_now | (status_r & ~{NUM_CHECKS{sample_valid}});
                if (|(fault_now & static_mask_r)) begin
                    mode_nxt = SFS_STATIC_FAULT;
                end else if (!(|status_nxt)) begin
                    mode_nxt = SFS_NORMAL;
                end
            end
            SFS_STATIC_FAULT: begin
                status_nxt = status_r | fault_now;
                mode_nxt = SFS_STATIC_FAULT;
            end
            default: mode_nxt = SFS_STATIC_FAULT;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n || analog_supply_power_reset || digital_supply_brownout) begin
            mode_r <= SFS_NORMAL;
            status_r <= '0;
            wdg_cnt_r <= '0;
            wdg_fault_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            status_r <= status_nxt;
            wdg_cnt_r <= wdg_cnt_nxt;
            wdg_fault_r <= wdg_fault_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            osc_cnt_r <= '0;
            osc_lost_r <= 1'b0;
            osc_restart_r <= 1'b0;
        end else begin
            osc_cnt_r <= osc_cnt_nxt;
            osc_lost_r <= osc_lost_nxt;
            osc_restart_r <= osc_restart_nxt;
        end
    end

    // Output path and link read port.
    always_comb begin
        dac_nxt = dac_r;
        if (mode_r == SFS_NORMAL) begin
            dac_nxt = result_r[DW-1 -: 12];
        end else begin
            dac_nxt = high_band_r ? DAC_HIGH_BAND : DAC_LOW_BAND;
        end
        rdata_nxt = '0;
        if (link_rd) begin
            case (link_addr)
                ADDR_CTRL: rdata_nxt = DW'({self_rst_en_r, hiz_r, lock_r});
                ADDR_STATIC_MASK: rdata_nxt = DW'(static_mask_r);
                ADDR_BRIDGE_MIN: rdata_nxt = br_min_r;
                ADDR_BRIDGE_MAX: rdata_nxt = br_max_r;
                ADDR_TEMP_MIN: rdata_nxt = t_min_r;
                ADDR_TEMP_MAX: rdata_nxt = t_max_r;
                ADDR_STEP_MAX: rdata_nxt = step_max_r;
                ADDR_STATUS: rdata_nxt = DW'(status_r);
                ADDR_RESULT: rdata_nxt = result_r;
                ADDR_MODE: rdata_nxt = DW'(mode_r);
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dac_r <= DAC_LOW_BAND;
            rdata_r <= '0;
        end else begin
            dac_r <= dac_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign link_rdata = rdata_r;
    assign dac_code = dac_r;
    assign analog_result_oe = !(hiz_r && (mode_r != SFS_NORMAL));
    assign conditioning_run = run;
    assign fault_report_mode = mode_r;
    assign self_reset_req = (self_rst_en_r && (mode_r == SFS_STATIC_FAULT)) || osc_restart_r;
endmodule : sfs_supervisor
`default_nettype wire

/* File: rtl/sfs_pkg.sv */
package sfs_pkg;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned WDG_WIN_OPEN_US = 10;
    localparam int unsigned WDG_WIN_CLOSE_US = 20;
    localparam int unsigned WDG_OPEN_CYC = WDG_WIN_OPEN_US * CLK_MHZ;
    localparam int unsigned WDG_CLOSE_CYC = WDG_WIN_CLOSE_US * CLK_MHZ;
    localparam int unsigned OSC_TIMEOUT_CYC = 64;
    localparam int unsigned NUM_CHECKS = 14;
    localparam int unsigned CHK_ANALOG_POR = 0;
    localparam int unsigned CHK_DIGITAL_BOD = 1;
    localparam int unsigned CHK_OSC_LOSS = 2;
    localparam int unsigned CHK_NVM_SUM = 3;
    localparam int unsigned CHK_ROM_SUM = 4;
    localparam int unsigned CHK_CYCLE_SUM = 5;
    localparam int unsigned CHK_RAM_PARITY = 6;
    localparam int unsigned CHK_ALIVE = 7;
    localparam int unsigned CHK_CALC_SAT = 8;
    localparam int unsigned CHK_DEC = 9;
    localparam int unsigned CHK_BRIDGE_RANGE = 10;
    localparam int unsigned CHK_BRIDGE_PLAUS = 11;
    localparam int unsigned CHK_TEMP_RANGE = 12;
    localparam int unsigned CHK_TEMP_PLAUS = 13;
    localparam logic [NUM_CHECKS-1:0] STATIC_MASK_RST = 14'h007F;
    localparam logic [11:0] DAC_LOW_BAND = 12'h000;
    localparam logic [11:0] DAC_HIGH_BAND = 12'hFFF;
    localparam logic [15:0] BRIDGE_MIN_RST = 16'h8000;
    localparam logic [15:0] BRIDGE_MAX_RST = 16'h7FFF;
    localparam logic [15:0] TEMP_MIN_RST = 16'h8000;
    localparam logic [15:0] TEMP_MAX_RST = 16'h7FFF;
    localparam logic [15:0] STEP_MAX_RST = 16'h4000;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATIC_MASK = 4'h1;
    localparam logic [3:0] ADDR_BRIDGE_MIN = 4'h2;
    localparam logic [3:0] ADDR_BRIDGE_MAX = 4'h3;
    localparam logic [3:0] ADDR_TEMP_MIN = 4'h4;
    localparam logic [3:0] ADDR_TEMP_MAX = 4'h5;
    localparam logic [3:0] ADDR_STEP_MAX = 4'h6;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_RESULT = 4'h9;
    localparam logic [3:0] ADDR_MODE = 4'hA;
    localparam int unsigned CTRL_LOCK_BIT = 0;
    localparam int unsigned CTRL_HIZ_BIT = 1;
    localparam int unsigned CTRL_SELF_RST_BIT = 2;
    typedef enum logic [1:0] {
        SFS_NORMAL = 2'b00,
        SFS_TEMP_FAULT = 2'b01,
        SFS_STATIC_FAULT = 2'b11
    } sfs_mode_t;
endpackage : sfs_pkg

/* File: verification/sfs_supervisor_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sfs_supervisor_props
    import sfs_pkg::*;
#(
    parameter int unsigned DW = 16,
    parameter int unsigned WDG_OPEN = WDG_OPEN_CYC,
    parameter int unsigned WDG_CLOSE = WDG_CLOSE_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic analog_supply_power_reset,
    input wire logic digital_supply_brownout,
    input wire logic sample_valid,
    input wire logic sample_is_temp,
    input wire logic [DW-1:0] calc_result,
    input wire logic calc_saturated,
    input wire logic nonvolatile_checksum_err,
    input wire logic rom_checksum_err,
    input wire logic cycle_checksum_err,
    input wire logic ram_parity_err,
    input wire logic output_decoder_err,
    input wire logic [3:0] link_addr,
    input wire logic link_rd,
    input wire logic [DW-1:0] link_rdata,
    input wire logic [11:0] dac_code,
    input wire logic analog_result_oe,
    input wire logic conditioning_run,
    input wire logic [1:0] fault_report_mode
);
    logic ok;
    logic diag;
    logic mem_bad;
    // Supply faults hold the mode, status and watchdog in reset, so fault reactions are only expected outside them.
    assign ok = !analog_supply_power_reset && !digital_supply_brownout;
    assign diag = fault_report_mode != SFS_NORMAL;
    assign mem_bad = nonvolatile_checksum_err || rom_checksum_err || cycle_checksum_err || ram_parity_err;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    a_dac_follows: assert property (
        sample_valid && !sample_is_temp && !diag ##1 !diag ##1 !diag |-> dac_code == $past(calc_result[15:4], 2))
        else $error("dac code does not follow the result");
    a_diag_band: assert property (
        diag [*2] |-> dac_code == DAC_LOW_BAND || dac_code == DAC_HIGH_BAND)
        else $error("diagnostic output outside the bands");
    a_normal_drive: assert property (
        !diag [*2] |-> analog_result_oe)
        else $error("output not driven in normal mode");
    a_run_not_static: assert property (
        conditioning_run == (fault_report_mode != SFS_STATIC_FAULT))
        else $error("conditioning run flag wrong for the mode");
    a_static_holds: assert property (
        fault_report_mode == SFS_STATIC_FAULT && ok ##1 ok |-> fault_report_mode == SFS_STATIC_FAULT)
        else $error("static mode left without reset");
    a_mem_static: assert property (
        ok && mem_bad ##1 ok |-> fault_report_mode == SFS_STATIC_FAULT)
        else $error("memory check fault did not enter static mode");
    a_decoder_diag: assert property (
        ok && output_decoder_err ##1 ok |-> diag)
        else $error("decoder fault did not enter diagnostic mode");
    a_sat_diag: assert property (
        ok && sample_valid && calc_saturated ##1 ok |-> diag)
        else $error("saturation did not enter diagnostic mode");
    a_rdata_quiet: assert property (
        !$past(link_rd) |-> link_rdata == '0)
        else $error("read data not zero outside a read");
    a_mode_read: assert property (
        $past(link_rd) && $past(link_addr) == ADDR_MODE |-> link_rdata[1:0] == $past(fault_report_mode))
        else $error("mode read back wrong");
endmodule : sfs_supervisor_props
bind sfs_supervisor sfs_supervisor_props #(.DW(DW), .WDG_OPEN(WDG_OPEN), .WDG_CLOSE(WDG_CLOSE)) u_props (
    .clk, .reset_n, .analog_supply_power_reset, .digital_supply_brownout, .sample_valid, .sample_is_temp,
    .calc_result, .calc_saturated, .nonvolatile_checksum_err, .rom_checksum_err, .cycle_checksum_err,
    .ram_parity_err, .output_decoder_err, .link_addr, .link_rd, .link_rdata, .dac_code, .analog_result_oe,
    .conditioning_run, .fault_report_mode
);
`default_nettype wire

/* File: verification/sfs_ecu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sfs_ecu_model
    import sfs_pkg::*;
(
    input wire logic clk,
    input wire logic tie_ground,
    input wire logic [11:0] dac_code,
    input wire logic analog_result_oe,
    output logic fault_band_strap_pin,
    output logic [1:0] reading
);
    // strap to ground
    // The pin has a pull-up, so an untied pin reads high.
    assign fault_band_strap_pin = !tie_ground;
    // Reading codes: 0 floating, 1 low band, 2 high band, 3 sensor value.
    always @(posedge clk) begin
        if (!analog_result_oe) begin
            reading <= 2'h0;
        end else if (dac_code == DAC_LOW_BAND) begin
            reading <= 2'h1;
        end else if (dac_code == DAC_HIGH_BAND) begin
            reading <= 2'h2;
        end else begin
            reading <= 2'h3;
        end
    end
endmodule : sfs_ecu_model
`default_nettype wire

/* File: verification/tb_sensor_fault_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_fault_supervisor;
    import sfs_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, osc_tick = 1'b0, osc_en = 1'b1, tie_ground = 1'b0;
    logic sample_valid = 1'b0, sample_is_temp = 1'b0, calc_saturated = 1'b0, alive_service = 1'b0;
    logic output_decoder_err = 1'b0, link_wr = 1'b0, link_rd = 1'b0;
    logic [1:0] supply = 2'h0;
    logic [3:0] mem_err = 4'h0, link_addr = 4'h0;
    logic [15:0] sample_data = 16'h0000, calc_result = 16'h0000, link_wdata = 16'h0000, link_rdata, rv;
    logic [11:0] dac_code;
    logic [1:0] fault_report_mode, reading;
    logic analog_result_oe, conditioning_run, self_reset_req, fault_band_strap_pin;
    logic [7:0] wcnt = 8'h00, wper = 8'h08;
    int fails = 0, compares = 0, cycles = 0;
    sfs_supervisor #(.DW(16), .WDG_OPEN(4), .WDG_CLOSE(16)) DUT (
        .clk, .reset_n, .analog_supply_power_reset(supply[0]), .digital_supply_brownout(supply[1]),
        .osc_tick, .sample_valid, .sample_is_temp, .sample_data, .calc_result, .calc_saturated,
        .alive_service, .nonvolatile_checksum_err(mem_err[0]), .rom_checksum_err(mem_err[1]),
        .cycle_checksum_err(mem_err[2]), .ram_parity_err(mem_err[3]), .output_decoder_err,
        .fault_band_strap_pin, .link_addr, .link_wdata, .link_wr, .link_rd, .link_rdata, .dac_code,
        .analog_result_oe, .conditioning_run, .fault_report_mode, .self_reset_req
    );
    sfs_ecu_model u_ecu (.clk, .tie_ground, .dac_code, .analog_result_oe, .fault_band_strap_pin, .reading);
    always #2.5 clk = ~clk;
    always #10 if (osc_en) osc_tick = ~osc_tick;
    // Service restarts with every reset, else the first service could land inside the closed window.
    always @(posedge clk) begin
        if (!reset_n || supply != 2'h0 || wcnt == wper - 8'h01) begin
            wcnt <= 8'h00;
        end else begin
            wcnt <= wcnt + 8'h01;
        end
        alive_service <= reset_n && supply == 2'h0 && wcnt == wper - 8'h01;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cm(input logic [1:0] m);
        chk("mode", 16'(m), 16'(fault_report_mode));
    endtask : cm
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic do_reset();
        @(posedge clk);
        reset_n <= 1'b0;
        {supply, mem_err, output_decoder_err, tie_ground} <= '0;
        wper <= 8'h08;
        osc_en = 1'b1;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
    endtask : do_reset
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        link_addr <= a;
        link_wdata <= d;
        link_wr <= 1'b1;
        @(posedge clk);
        link_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        link_addr <= a;
        link_rd <= 1'b1;
        @(posedge clk);
        link_rd <= 1'b0;
        #1 rv = link_rdata;
    endtask : rd
    task automatic smp(input logic t, input logic [15:0] d, input logic [15:0] r, input logic s);
        @(posedge clk);
        {sample_valid, sample_is_temp, sample_data, calc_result, calc_saturated} <= {1'b1, t, d, r, s};
        @(posedge clk);
        {sample_valid, calc_saturated} <= 2'h0;
    endtask : smp
    task automatic t_regs();
        logic [3:0] ad [11];
        logic [15:0] ex [11];
        ad = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hF};
        ex = '{16'h0000, 16'(STATIC_MASK_RST), BRIDGE_MIN_RST, BRIDGE_MAX_RST, TEMP_MIN_RST, TEMP_MAX_RST,
            STEP_MAX_RST, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
        for (int i = 7; i < 11; i++) wr(ad[i], 16'hFFFF);
        for (int i = 0; i < 11; i++) begin
            rd(ad[i]);
            chk("register", ex[i], rv);
        end
        chk("oe", 16'h0001, 16'(analog_result_oe));
        chk("self reset", 16'h0000, 16'(self_reset_req));
    endtask : t_regs
    task automatic t_normal();
        logic [15:0] res [3];
        res = '{16'h1234, 16'hABCD, 16'h0FF0};
        for (int i = 0; i < 3; i++) begin
            smp(1'b0, 16'h0010, res[i], 1'b0);
            smp(1'b1, 16'h0020, 16'h5A5A, 1'b0);
            tick(2);
            chk("dac", 16'(res[i][15:4]), 16'(dac_code));
            chk("ecu value", 16'h0003, 16'(reading));
            rd(ADDR_RESULT);
            chk("result", res[i], rv);
        end
    endtask : t_normal
    task automatic t_temp();
        do_reset();
        smp(1'b0, 16'h0010, 16'h1111, 1'b0);
        output_decoder_err <= 1'b1;
        @(posedge clk);
        output_decoder_err <= 1'b0;
        tick(2);
        cm(SFS_TEMP_FAULT);
        chk("low band", 16'(DAC_LOW_BAND), 16'(dac_code));
        chk("ecu low", 16'h0001, 16'(reading));
        chk("run", 16'h0001, 16'(conditioning_run));
        rd(ADDR_STATUS);
        chk("status", 16'h0200, rv);
        rd(ADDR_MODE);
        chk("mode read", 16'h0001, rv);
        output_decoder_err <= 1'b1;
        smp(1'b0, 16'h0010, 16'h1111, 1'b0);
        output_decoder_err <= 1'b0;
        tick(2);
        cm(SFS_TEMP_FAULT);
        smp(1'b0, 16'h0010, 16'h2222, 1'b0);
        tick(3);
        cm(SFS_NORMAL);
        chk("dac back", 16'h0222, 16'(dac_code));
        tie_ground <= 1'b1;
        smp(1'b0, 16'h0010, 16'h3333, 1'b1);
        tick(6);
        cm(SFS_TEMP_FAULT);
        chk("high band", 16'(DAC_HIGH_BAND), 16'(dac_code));
        chk("ecu high", 16'h0002, 16'(reading));
        rd(ADDR_STATUS);
        chk("sat status", 16'h0100, rv);
        wr(ADDR_CTRL, 16'h0002);
        tick(2);
        chk("hiz", 16'h0000, 16'(analog_result_oe));
        smp(1'b0, 16'h0010, 16'h4444, 1'b0);
        tick(3);
        cm(SFS_NORMAL);
        chk("oe back", 16'h0001, 16'(analog_result_oe));
    endtask : t_temp
    task automatic t_range();
        for (int i = 0; i < 4; i++) begin
            do_reset();
            wr(i[0] ? ADDR_STEP_MAX : (i[1] ? ADDR_TEMP_MAX : ADDR_BRIDGE_MAX), 16'h0100);
            smp(i[1], 16'h0000, 16'h0000, 1'b0);
            smp(i[1], 16'h0200, 16'h0000, 1'b0);
            tick(2);
            cm(SFS_TEMP_FAULT);
            rd(ADDR_STATUS);
            chk("range status", 16'h0400 << i, rv);
        end
    endtask : t_range
    task automatic t_wdg();
        for (int i = 0; i < 2; i++) begin
            do_reset();
            wper <= i ? 8'h02 : 8'hC8;
            tick(40);
            cm(SFS_TEMP_FAULT);
            rd(ADDR_STATUS);
            chk("alive status", 16'h0080, rv);
        end
    endtask : t_wdg
    task automatic t_mem();
        for (int i = 0; i < 6; i++) begin
            do_reset();
            @(posedge clk);
            if (i < 4) mem_err[i] <= 1'b1;
            else {supply[i-4], mem_err[0]} <= 2'h3;
            tick(10);
            if (i >= 4) begin
                cm(SFS_NORMAL);
                supply <= 2'h0;
                @(posedge clk);
            end
            mem_err <= 4'h0;
            tick(2);
            cm(SFS_STATIC_FAULT);
            rd(ADDR_STATUS);
            if (i < 4) chk("mem status", 16'h0008 << i, rv & (16'h0008 << i));
        end
    endtask : t_mem
    task automatic t_static();
        int n;
        do_reset();
        smp(1'b0, 16'h0010, 16'h5555, 1'b0);
        osc_en = 1'b0;
        tick(100);
        cm(SFS_STATIC_FAULT);
        chk("run", 16'h0000, 16'(conditioning_run));
        rd(ADDR_STATUS);
        chk("osc status", 16'h0004, rv & 16'h0004);
        smp(1'b0, 16'h0010, 16'h6666, 1'b0);
        tick(2);
        rd(ADDR_RESULT);
        chk("frozen result", 16'h5555, rv);
        osc_en = 1'b1;
        for (n = 0; n < 40 && self_reset_req !== 1'b1; n++) tick(1);
        chk("restart reset", 16'h0001, 16'(self_reset_req));
        tick(40);
        cm(SFS_STATIC_FAULT);
        wr(ADDR_CTRL, 16'h0004);
        tick(2);
        chk("self reset", 16'h0001, 16'(self_reset_req));
    endtask : t_static
    task automatic t_lock();
        do_reset();
        wr(ADDR_BRIDGE_MIN, 16'h8001);
        wr(ADDR_CTRL, 16'h0001);
        wr(ADDR_BRIDGE_MIN, 16'h9000);
        wr(ADDR_CTRL, 16'h0000);
        rd(ADDR_BRIDGE_MIN);
        chk("locked value", 16'h8001, rv);
        rd(ADDR_CTRL);
        chk("lock bit", 16'h0001, rv);
    endtask : t_lock
    initial begin
        do_reset();
        t_regs();
        t_normal();
        t_temp();
        t_range();
        t_wdg();
        t_mem();
        t_static();
        t_lock();
        tally_and_finish();
    end
endmodule : tb_sensor_fault_supervisor
`default_nettype wire
